// ==== uref_core.sv ====
// Serial port with receive error status, error clear and flag registers.
// Assumes a single 50 MHz clock, a plain register port and asynchronous line pins.
`timescale 1ns/10ps
`default_nettype none

module uref_core (
   // Clock and synchronous reset.
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port.
   input wire logic [uref_pkg::ADDR_W-1:0] addr,
   input wire logic [uref_pkg::DATA_W-1:0] wr_data,
   input wire logic wr_en,
   input wire logic rd_en,
   output logic [uref_pkg::DATA_W-1:0] rd_data,
   // Serial line.
   input wire logic rx_in,
   output logic tx_out,
   // Modem status inputs, active low.
   input wire logic ring_in_n,
   input wire logic carrier_in_n,
   input wire logic set_ready_in_n,
   input wire logic clear_send_in_n
);

   typedef struct packed {
      logic rx_meta;
      logic rx_pin;
      logic [3:0] mdm_meta;
      logic [3:0] mdm_n;
      logic [15:0] ibrd;
      logic [7:0] line_control_reg;
      logic [15:0] ctrl;
      logic [15:0] baud_cnt;
      logic tick;
      uref_pkg::uref_rx_t rx_state;
      logic [3:0] rx_tk;
      logic [2:0] rx_bit;
      logic [7:0] rx_data;
      logic rx_par_bad;
      logic rx_all_zero;
      logic rx_ovr_pend;
      logic [uref_pkg::FIFO_DEPTH-1:0][uref_pkg::ENT_W-1:0] rx_fifo;
      logic [3:0] rx_wp;
      logic [3:0] rx_rp;
      logic [4:0] rx_cnt;
      logic [uref_pkg::FIFO_DEPTH-1:0][7:0] tx_fifo;
      logic [3:0] tx_wp;
      logic [3:0] tx_rp;
      logic [4:0] tx_cnt;
      uref_pkg::uref_tx_t tx_state;
      logic [3:0] tx_tk;
      logic [2:0] tx_bit;
      logic [7:0] tx_sh;
      logic tx_par;
      logic tx_line;
      logic [3:0] rx_error_status_reg;
      logic [15:0] rd_data;
   } uref_st_t;

   uref_st_t q;
   uref_st_t n;

   // Event strobes shared with the checks below.
   logic ovr_evt;
   logic brk_push;
   logic rx_pop;
   logic push_req;
   logic [uref_pkg::ENT_W-1:0] push_ent;
   logic [15:0] flag_word;

   // Parity of the low bits of a character, masked to the word length.
   function automatic logic par_of(input logic [7:0] d, input logic [2:0] nbm1);
      logic p;
      p = 1'b0;
      for (int i = 0; i < 8; i++) begin
         if (3'(i) <= nbm1) begin
            p = p ^ d[i];
         end
      end
      return p;
   endfunction

   // Flag word built from live state; reserved bits stay zero.
   always_comb begin
      logic fifo_enable;
      logic [4:0] cap;
      fifo_enable = q.line_control_reg[uref_pkg::LCR_FEN];
      cap = fifo_enable ? uref_pkg::CAP_FIFO : uref_pkg::CAP_HOLD;
      flag_word = '0;
      flag_word[uref_pkg::FLG_RI] = ~q.mdm_n[3];
      flag_word[uref_pkg::FLG_DCD] = ~q.mdm_n[2];
      flag_word[uref_pkg::FLG_DSR] = ~q.mdm_n[1];
      flag_word[uref_pkg::FLG_CTS] = ~q.mdm_n[0];
      flag_word[uref_pkg::FLG_TX_EMPTY_FLAG] = (q.tx_cnt == '0);
      flag_word[uref_pkg::FLG_RX_FULL_FLAG] = (q.rx_cnt >= cap);
      flag_word[uref_pkg::FLG_TX_FULL_FLAG] = (q.tx_cnt >= cap);
      flag_word[uref_pkg::FLG_RX_EMPTY_FLAG] = (q.rx_cnt == '0);
      // Busy also covers a queued entry so software sees it even while disabled.
      flag_word[uref_pkg::FLG_BUSY] = (q.tx_cnt != '0) || (q.tx_state != uref_pkg::TX_IDLE);
   end

   // Next-state logic for the whole block.
   always_comb begin
      logic [2:0] nbm1;
      logic [4:0] cap;
      logic rx_go;
      logic tx_go;
      nbm1 = q.line_control_reg[uref_pkg::LCR_WLEN +: 2] + uref_pkg::WLEN_BASE;
      cap = q.line_control_reg[uref_pkg::LCR_FEN] ? uref_pkg::CAP_FIFO : uref_pkg::CAP_HOLD;
      rx_go = q.ctrl[uref_pkg::CR_EN] && q.ctrl[uref_pkg::CR_RXE];
      tx_go = q.ctrl[uref_pkg::CR_EN] && q.ctrl[uref_pkg::CR_TXE];
      n = q;
      ovr_evt = 1'b0;
      brk_push = 1'b0;
      rx_pop = 1'b0;
      push_req = 1'b0;
      push_ent = '0;
      n.tick = 1'b0;
      n.rd_data = '0;

      // Two-stage synchronisers on every pin.
      n.rx_meta = rx_in;
      n.rx_pin = q.rx_meta;
      n.mdm_meta = {ring_in_n, carrier_in_n, set_ready_in_n, clear_send_in_n};
      n.mdm_n = q.mdm_meta;

      // Sixteen-times bit rate tick; a zero divisor stops the tick.
      if (q.ibrd != '0) begin
         if (q.baud_cnt >= q.ibrd - 16'h0001) begin
            n.baud_cnt = '0;
            n.tick = 1'b1;
         end else begin
            n.baud_cnt = q.baud_cnt + 16'h0001;
         end
      end

      // Register writes.
      if (wr_en) begin
         unique case (addr)
            uref_pkg::OFS_DATA: begin
               if (q.tx_cnt < cap) begin
                  n.tx_fifo[q.tx_wp] = wr_data[7:0];
                  n.tx_wp = q.tx_wp + 4'h1;
                  n.tx_cnt = q.tx_cnt + 5'h01;
               end
            end
            uref_pkg::OFS_RSR: n.rx_error_status_reg = '0;
            uref_pkg::OFS_IBRD: n.ibrd = wr_data;
            uref_pkg::OFS_LCR: n.line_control_reg = wr_data[7:0];
            uref_pkg::OFS_CR: n.ctrl = wr_data;
            default: ;
         endcase
      end

      // Register reads; answer stands one cycle after the strobe.
      if (rd_en) begin
         unique case (addr)
            uref_pkg::OFS_DATA: begin
               if (q.rx_cnt != '0) begin
                  rx_pop = 1'b1;
                  n.rd_data = {4'h0, q.rx_fifo[q.rx_rp]};
                  // Head entry's framing, parity and break errors move into status on each data read.
                  n.rx_error_status_reg[uref_pkg::RSE_BE:uref_pkg::RSE_FE] =
                     q.rx_fifo[q.rx_rp][uref_pkg::ENT_FE +: 3];
                  n.rx_rp = q.rx_rp + 4'h1;
                  n.rx_cnt = q.rx_cnt - 5'h01;
               end
            end
            uref_pkg::OFS_RSR: n.rd_data = {12'h000, q.rx_error_status_reg};
            uref_pkg::OFS_FLAG: n.rd_data = flag_word;
            uref_pkg::OFS_IBRD: n.rd_data = q.ibrd;
            uref_pkg::OFS_LCR: n.rd_data = {8'h00, q.line_control_reg};
            uref_pkg::OFS_CR: n.rd_data = q.ctrl;
            default: n.rd_data = '0;
         endcase
      end

      // Receiver, sampling mid-bit on the sixteen-times tick.
      if (q.tick) begin
         unique case (q.rx_state)
            uref_pkg::RX_IDLE: begin
               if (rx_go && !q.rx_pin) begin
                  n.rx_state = uref_pkg::RX_START;
                  n.rx_tk = '0;
               end
            end
            uref_pkg::RX_START: begin
               n.rx_tk = q.rx_tk + 4'h1;
               if (q.rx_tk == uref_pkg::TICK_MID) begin
                  n.rx_tk = '0;
                  n.rx_bit = '0;
                  n.rx_data = '0;
                  n.rx_all_zero = 1'b1;
                  n.rx_par_bad = 1'b0;
                  n.rx_state = q.rx_pin ? uref_pkg::RX_IDLE : uref_pkg::RX_DATA;
               end
            end
            uref_pkg::RX_DATA: begin
               n.rx_tk = q.rx_tk + 4'h1;
               if (q.rx_tk == uref_pkg::TICK_LAST) begin
                  n.rx_data[q.rx_bit] = q.rx_pin;
                  n.rx_all_zero = q.rx_all_zero && !q.rx_pin;
                  n.rx_bit = q.rx_bit + 3'h1;
                  if (q.rx_bit == nbm1) begin
                     n.rx_state = q.line_control_reg[uref_pkg::LCR_PEN] ? uref_pkg::RX_PAR : uref_pkg::RX_STOP;
                  end
               end
            end
            uref_pkg::RX_PAR: begin
               n.rx_tk = q.rx_tk + 4'h1;
               if (q.rx_tk == uref_pkg::TICK_LAST) begin
                  n.rx_all_zero = q.rx_all_zero && !q.rx_pin;
                  // Stick parity sends the inverse of the even select bit.
                  if (q.line_control_reg[uref_pkg::LCR_SPS]) begin
                     n.rx_par_bad = (q.rx_pin != !q.line_control_reg[uref_pkg::LCR_EPS]);
                  end else begin
                     n.rx_par_bad = (par_of(q.rx_data, nbm1) ^ q.rx_pin) != !q.line_control_reg[uref_pkg::LCR_EPS];
                  end
                  n.rx_state = uref_pkg::RX_STOP;
               end
            end
            uref_pkg::RX_STOP: begin
               n.rx_tk = q.rx_tk + 4'h1;
               if (q.rx_tk == uref_pkg::TICK_LAST) begin
                  n.rx_tk = '0;
                  if (!q.rx_pin && q.rx_all_zero) begin
                     // Whole frame low so far: watch half a bit more, up to TICK_MID, before calling it a break.
                     n.rx_state = uref_pkg::RX_BRK;
                  end else begin
                     push_req = 1'b1;
                     push_ent = {1'b0, 1'b0, q.rx_par_bad, !q.rx_pin, q.rx_data};
                     n.rx_state = uref_pkg::RX_IDLE;
                  end
               end
            end
            uref_pkg::RX_BRK: begin
               n.rx_tk = q.rx_tk + 4'h1;
               if (q.rx_pin) begin
                  // Line rose inside the frame margin: plain framing error.
                  push_req = 1'b1;
                  push_ent = {1'b0, 1'b0, q.rx_par_bad, 1'b1, q.rx_data};
                  n.rx_state = uref_pkg::RX_IDLE;
               end else if (q.rx_tk == uref_pkg::TICK_MID) begin
                  brk_push = 1'b1;
                  push_req = 1'b1;
                  push_ent = {1'b0, 1'b1, 1'b0, 1'b1, 8'h00};
                  n.rx_state = uref_pkg::RX_WAIT;
               end
            end
            uref_pkg::RX_WAIT: begin
               if (q.rx_pin) begin
                  n.rx_state = uref_pkg::RX_IDLE;
               end
            end
            default: n.rx_state = uref_pkg::RX_IDLE;
         endcase
      end

      // Store a finished character, or drop it and flag overrun when full.
      if (push_req) begin
         if (n.rx_cnt >= cap) begin
            ovr_evt = 1'b1;
            n.rx_ovr_pend = 1'b1;
         end else begin
            n.rx_fifo[q.rx_wp] = push_ent | {q.rx_ovr_pend, 11'h000};
            n.rx_wp = q.rx_wp + 4'h1;
            n.rx_cnt = n.rx_cnt + 5'h01;
            n.rx_ovr_pend = 1'b0;
         end
      end
      // Overrun sets at once and wins over a clear in the same cycle.
      if (ovr_evt) begin
         n.rx_error_status_reg[uref_pkg::RSE_OE] = 1'b1;
      end

      // Transmitter; a character in flight finishes even after EN or TXE clears, but stalls while the divisor is zero.
      if (q.tick) begin
         unique case (q.tx_state)
            uref_pkg::TX_IDLE: begin
               n.tx_line = 1'b1;
               if (tx_go && q.tx_cnt != '0) begin
                  n.tx_sh = q.tx_fifo[q.tx_rp];
                  n.tx_par = q.line_control_reg[uref_pkg::LCR_SPS] ? !q.line_control_reg[uref_pkg::LCR_EPS]
                     : (par_of(q.tx_fifo[q.tx_rp], nbm1) ^ !q.line_control_reg[uref_pkg::LCR_EPS]);
                  n.tx_rp = q.tx_rp + 4'h1;
                  n.tx_cnt = n.tx_cnt - 5'h01;
                  n.tx_line = 1'b0;
                  n.tx_tk = '0;
                  n.tx_state = uref_pkg::TX_START;
               end
            end
            uref_pkg::TX_START: begin
               n.tx_tk = q.tx_tk + 4'h1;
               if (q.tx_tk == uref_pkg::TICK_LAST) begin
                  n.tx_line = q.tx_sh[0];
                  n.tx_bit = '0;
                  n.tx_state = uref_pkg::TX_DATA;
               end
            end
            uref_pkg::TX_DATA: begin
               n.tx_tk = q.tx_tk + 4'h1;
               if (q.tx_tk == uref_pkg::TICK_LAST) begin
                  n.tx_sh = {1'b0, q.tx_sh[7:1]};
                  n.tx_bit = q.tx_bit + 3'h1;
                  n.tx_line = q.tx_sh[1];
                  if (q.tx_bit == nbm1) begin
                     n.tx_bit = '0;
                     if (q.line_control_reg[uref_pkg::LCR_PEN]) begin
                        n.tx_line = q.tx_par;
                        n.tx_state = uref_pkg::TX_PAR;
                     end else begin
                        n.tx_line = 1'b1;
                        n.tx_state = uref_pkg::TX_STOP;
                     end
                  end
               end
            end
            uref_pkg::TX_PAR: begin
               n.tx_tk = q.tx_tk + 4'h1;
               if (q.tx_tk == uref_pkg::TICK_LAST) begin
                  n.tx_line = 1'b1;
                  n.tx_state = uref_pkg::TX_STOP;
               end
            end
            uref_pkg::TX_STOP: begin
               n.tx_tk = q.tx_tk + 4'h1;
               if (q.tx_tk == uref_pkg::TICK_LAST) begin
                  // Busy drops only after the last stop bit has gone.
                  if (q.line_control_reg[uref_pkg::LCR_STP2] && q.tx_bit == '0) begin
                     n.tx_bit = 3'h1;
                  end else begin
                     n.tx_state = uref_pkg::TX_IDLE;
                  end
               end
            end
            default: n.tx_state = uref_pkg::TX_IDLE;
         endcase
      end
   end

   // State register; reset leaves both FIFOs empty and the line marking.
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         q <= '0;
         q.rx_meta <= 1'b1;
         q.rx_pin <= 1'b1;
         q.mdm_meta <= 4'hF;
         q.mdm_n <= 4'hF;
         q.ibrd <= uref_pkg::IBRD_RST;
         q.line_control_reg <= uref_pkg::LCR_RST;
         q.ctrl <= uref_pkg::CR_RST;
         q.rx_state <= uref_pkg::RX_IDLE;
         q.tx_state <= uref_pkg::TX_IDLE;
         q.tx_line <= 1'b1;
         q.rx_error_status_reg <= uref_pkg::RSE_RST;
      end else begin
         q <= n;
      end
   end

   assign rd_data = q.rd_data;
   assign tx_out = q.tx_line;

   // Checks on the status behaviour.
   property p_ecr_clear;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && addr == uref_pkg::OFS_RSR) |=> (q.rx_error_status_reg[2:0] == 3'h0);
   endproperty
   a_ecr_clear: assert property (p_ecr_clear) else $error("Error clear left a bit set.");

   property p_ovr_set;
      @(posedge clk_sys) disable iff (!rst_n)
      ovr_evt |=> q.rx_error_status_reg[uref_pkg::RSE_OE] && q.rx_ovr_pend;
   endproperty
   a_ovr_set: assert property (p_ovr_set) else $error("Overrun not flagged.");

   property p_ovr_keep;
      @(posedge clk_sys) disable iff (!rst_n)
      (ovr_evt && !rx_pop) |=> (q.rx_cnt == $past(q.rx_cnt)) && (q.rx_wp == $past(q.rx_wp));
   endproperty
   a_ovr_keep: assert property (p_ovr_keep) else $error("Overrun wrote into a full FIFO.");

   property p_brk_wait;
      @(posedge clk_sys) disable iff (!rst_n)
      brk_push |=> (q.rx_state == uref_pkg::RX_WAIT) && !q.rx_pin;
   endproperty
   a_brk_wait: assert property (p_brk_wait) else $error("Break did not wait for marking line.");

   property p_rd_status;
      @(posedge clk_sys) disable iff (!rst_n)
      rx_pop |=> (q.rx_error_status_reg[uref_pkg::RSE_BE:uref_pkg::RSE_FE] == $past(q.rx_fifo[q.rx_rp][uref_pkg::ENT_FE +: 3]))
         && (q.rd_data[uref_pkg::ENT_W-1:0] == $past(q.rx_fifo[q.rx_rp]));
   endproperty
   a_rd_status: assert property (p_rd_status) else $error("Status does not match read character.");

   property p_flag_resv;
      @(posedge clk_sys) disable iff (!rst_n)
      (rd_en && addr == uref_pkg::OFS_FLAG) |=> (rd_data[uref_pkg::DATA_W-1:uref_pkg::FLG_RI+1] == 7'h00)
         && (rd_data[uref_pkg::FLG_BUSY] == $past(flag_word[uref_pkg::FLG_BUSY]));
   endproperty
   a_flag_resv: assert property (p_flag_resv) else $error("Flag read shows reserved bits or wrong busy.");

   property p_busy_tx;
      @(posedge clk_sys) disable iff (!rst_n)
      // Busy must hold in every state of a frame, and the start bit must drive the line low.
      (q.tx_state != uref_pkg::TX_IDLE) |->
         flag_word[uref_pkg::FLG_BUSY] && ((q.tx_state != uref_pkg::TX_START) || !tx_out);
   endproperty
   a_busy_tx: assert property (p_busy_tx) else $error("Busy low during a frame.");

   property p_busy_fifo;
      @(posedge clk_sys) disable iff (!rst_n)
      (wr_en && addr == uref_pkg::OFS_DATA && q.tx_cnt == 5'h00) |=> flag_word[uref_pkg::FLG_BUSY];
   endproperty
   a_busy_fifo: assert property (p_busy_fifo) else $error("Busy not raised by a queued entry.");

   property p_rx_empty;
      @(posedge clk_sys) disable iff (!rst_n)
      (q.rx_cnt == 5'h00) |-> flag_word[uref_pkg::FLG_RX_EMPTY_FLAG] && !flag_word[uref_pkg::FLG_RX_FULL_FLAG];
   endproperty
   a_rx_empty: assert property (p_rx_empty) else $error("Receive empty flag wrong.");

   c_overrun: cover property (@(posedge clk_sys) disable iff (!rst_n) ovr_evt);
   c_break: cover property (@(posedge clk_sys) disable iff (!rst_n) brk_push);
   c_pop: cover property (@(posedge clk_sys) disable iff (!rst_n) rx_pop ##1 q.rx_error_status_reg[uref_pkg::RSE_PE]);
   c_tx: cover property (@(posedge clk_sys) disable iff (!rst_n) q.tx_state == uref_pkg::TX_STOP);

endmodule // uref_core

`default_nettype wire

// ==== uref_pkg.sv ====
// Constants, field positions and state types of the serial port status block.
// Assumes a 50 MHz system clock and a 16-bit plain register port.
package uref_pkg;

   // Register port widths.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 16;

   // Register offsets (byte addresses).
   localparam logic [11:0] OFS_DATA = 12'h000;
   localparam logic [11:0] OFS_RSR = 12'h004;
   localparam logic [11:0] OFS_FLAG = 12'h018;
   localparam logic [11:0] OFS_IBRD = 12'h024;
   localparam logic [11:0] OFS_LCR = 12'h02C;
   localparam logic [11:0] OFS_CR = 12'h030;

   // Reset values.
   localparam logic [15:0] CR_RST = 16'h0300;
   localparam logic [7:0] LCR_RST = 8'h00;
   localparam logic [15:0] IBRD_RST = 16'h0000;
   localparam logic [3:0] RSE_RST = 4'h0;

   // Line control and control fields.
   localparam int LCR_PEN = 1;
   localparam int LCR_EPS = 2;
   localparam int LCR_STP2 = 3;
   localparam int LCR_FEN = 4;
   localparam int LCR_WLEN = 5;
   localparam int LCR_SPS = 7;
   localparam int CR_EN = 0;
   localparam int CR_TXE = 8;
   localparam int CR_RXE = 9;

   // Error status bits and their places in a receive entry.
   localparam int RSE_OE = 3;
   localparam int RSE_BE = 2;
   localparam int RSE_PE = 1;
   localparam int RSE_FE = 0;
   localparam int ENT_FE = 8;
   localparam int ENT_OE = 11;

   // Flag register bits.
   localparam int FLG_RI = 8;
   localparam int FLG_TX_EMPTY_FLAG = 7;
   localparam int FLG_RX_FULL_FLAG = 6;
   localparam int FLG_TX_FULL_FLAG = 5;
   localparam int FLG_RX_EMPTY_FLAG = 4;
   localparam int FLG_BUSY = 3;
   localparam int FLG_DCD = 2;
   localparam int FLG_DSR = 1;
   localparam int FLG_CTS = 0;

   // FIFO shape and capacities in each mode.
   localparam int FIFO_DEPTH = 16;
   localparam int ENT_W = 12;
   localparam logic [4:0] CAP_FIFO = 5'h10;
   localparam logic [4:0] CAP_HOLD = 5'h01;

   // Oversampling: sixteen ticks a bit, sampled in the middle.
   localparam logic [3:0] TICK_LAST = 4'hF;
   localparam logic [3:0] TICK_MID = 4'h7;
   localparam logic [2:0] WLEN_BASE = 3'h4;

   typedef enum logic [2:0] {
      RX_IDLE = 3'h0, RX_START = 3'h1, RX_DATA = 3'h3, RX_PAR = 3'h2,
      RX_STOP = 3'h6, RX_BRK = 3'h7, RX_WAIT = 3'h5
   } uref_rx_t;

   typedef enum logic [2:0] {
      TX_IDLE = 3'h0, TX_START = 3'h1, TX_DATA = 3'h3, TX_PAR = 3'h2, TX_STOP = 3'h6
   } uref_tx_t;

endpackage

// ==== uref_peer.sv ====
// Remote serial device: drives the receive line and modem inputs, decodes tx_out.
// Assumes a divisor of 1, so one bit lasts 16 clocks of clk_sys.
`timescale 1ns/10ps
`default_nettype none
module uref_peer #(parameter int BIT = 16) (
   // Clock and transmit line seen from the port.
   input wire logic clk_sys,
   input wire logic tx_out,
   // Lines driven towards the port.
   output logic rx_in,
   output logic ring_in_n,
   output logic carrier_in_n,
   output logic set_ready_in_n,
   output logic clear_send_in_n
);
   logic [7:0] got;
   initial begin
      {rx_in, ring_in_n, carrier_in_n, set_ready_in_n, clear_send_in_n} = 5'h1F;
      got = 8'h00;
   end
   // Holds the line at one level for a number of bit times.
   task automatic hold(input logic v, input int n);
      rx_in <= v;
      repeat (n * BIT) @(posedge clk_sys);
   endtask
   // One frame, LSB first, even parity unless told to spoil it, then idle.
   task automatic send(input logic [7:0] d, input logic par_ok, input logic stop_v);
      @(posedge clk_sys);
      hold(1'b0, 1);
      for (int i = 0; i < 8; i++) hold(d[i], 1);
      hold(^d ^ ~par_ok, 1);
      hold(stop_v, 1);
      hold(1'b1, 2);
   endtask
   // Line low well past a full frame, then marking again.
   task automatic brk();
      @(posedge clk_sys);
      hold(1'b0, 14);
      hold(1'b1, 3);
   endtask
   // Samples each data bit in its middle; parity and stop are skipped.
   always begin
      @(negedge tx_out);
      repeat (BIT / 2) @(posedge clk_sys);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk_sys);
         got[i] = tx_out;
      end
      repeat (3 * BIT) @(posedge clk_sys);
   end
endmodule // uref_peer
`default_nettype wire

// ==== uref_core_bench.sv ====
// Self-checking bench: register tasks, then error status and flag sequences.
// Assumes uref_peer as far side and the register map of uref_pkg.
`timescale 1ns/10ps
`default_nettype none
module uref_core_bench;
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic [11:0] addr = 12'h000;
   logic [15:0] wr_data = 16'h0000;
   logic wr_en = 1'b0;
   logic rd_en = 1'b0;
   logic [15:0] rd_data;
   logic rx_in, tx_out, ri_n, cd_n, sr_n, cs_n;
   int n_fail = 0;
   int checks = 0;
   logic [15:0] v;
   // The first queued entry carries the overrun left pending by the holding-register test.
   logic [15:0] dr_exp [4] = '{16'h0A5A, 16'h0181, 16'h0500, 16'h00A5};
   logic [3:0] st_exp [4] = '{4'h2, 4'h1, 4'h5, 4'h0};

   always #10 clk_sys = ~clk_sys;

   uref_core uref_core_inst (.clk_sys(clk_sys), .rst_n(rst_n), .addr(addr), .wr_data(wr_data),
      .wr_en(wr_en), .rd_en(rd_en), .rd_data(rd_data), .rx_in(rx_in), .tx_out(tx_out),
      .ring_in_n(ri_n), .carrier_in_n(cd_n), .set_ready_in_n(sr_n), .clear_send_in_n(cs_n));
   uref_peer uref_peer_inst (.clk_sys(clk_sys), .tx_out(tx_out), .rx_in(rx_in), .ring_in_n(ri_n),
      .carrier_in_n(cd_n), .set_ready_in_n(sr_n), .clear_send_in_n(cs_n));

   // Comparison with four-state equality so an unknown never matches.
   task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] s);
      checks++;
      if (s !== e) begin
         n_fail++;
         $display("mismatch %s expected %h seen %h", nm, e, s);
      end
   endtask
   // One-cycle write strobe.
   task automatic wr(input logic [11:0] a, input logic [15:0] d);
      @(posedge clk_sys);
      wr_en <= 1'b1;
      addr <= a;
      wr_data <= d;
      @(posedge clk_sys);
      wr_en <= 1'b0;
   endtask
   // One-cycle read strobe; data is taken in the following cycle only.
   task automatic rd(input logic [11:0] a, output logic [15:0] d);
      @(posedge clk_sys);
      rd_en <= 1'b1;
      addr <= a;
      @(posedge clk_sys);
      rd_en <= 1'b0;
      #1 d = rd_data;
   endtask
   task automatic rdc(input logic [11:0] a, input logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk($sformatf("reg %h", a), e, d);
   endtask
   // Polls busy under a bound; a hang shows up in the next flag check.
   task automatic wait_idle();
      v = 16'hFFFF;
      for (int i = 0; i < 400 && v[uref_pkg::FLG_BUSY] !== 1'b0; i++) rd(uref_pkg::OFS_FLAG, v);
   endtask
   task automatic final_report();
      $display("checks %0d n_fail %0d", checks, n_fail);
      if (n_fail == 0 && checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // Watchdog, far beyond the few thousand cycles the sequence needs.
   initial begin
      repeat (30000) @(posedge clk_sys);
      n_fail++;
      final_report();
   end

   // Main sequence: queue while disabled then transmit, overrun without FIFO, queued errors with FIFO.
   initial begin
      repeat (20) @(posedge clk_sys);
      rst_n <= 1'b1;
      rdc(uref_pkg::OFS_FLAG, 16'h0090);
      rdc(uref_pkg::OFS_RSR, 16'h0000);
      wr(uref_pkg::OFS_DATA, 16'h00C3);
      rdc(uref_pkg::OFS_FLAG, 16'h0038);
      wr(uref_pkg::OFS_IBRD, 16'h0001);
      wr(uref_pkg::OFS_LCR, 16'h0066);
      wr(uref_pkg::OFS_CR, 16'h0301);
      repeat (40) @(posedge clk_sys);
      rdc(uref_pkg::OFS_FLAG, 16'h0098);
      wait_idle();
      repeat (40) @(posedge clk_sys);
      chk("tx byte", 16'h00C3, {8'h00, uref_peer_inst.got});
      uref_peer_inst.send(8'h3C, 1'b1, 1'b1);
      rdc(uref_pkg::OFS_FLAG, 16'h00C0);
      uref_peer_inst.send(8'h77, 1'b1, 1'b1);
      rdc(uref_pkg::OFS_RSR, 16'h0008);
      rdc(uref_pkg::OFS_DATA, 16'h003C);
      rdc(uref_pkg::OFS_FLAG, 16'h0090);
      wr(uref_pkg::OFS_RSR, 16'h0000);
      rdc(uref_pkg::OFS_RSR, 16'h0000);
      wr(uref_pkg::OFS_CR, 16'h0300);
      wr(uref_pkg::OFS_LCR, 16'h0076);
      wr(uref_pkg::OFS_CR, 16'h0301);
      // Four characters queue up before any read, so each status must follow the head.
      uref_peer_inst.send(8'h5A, 1'b0, 1'b1);
      uref_peer_inst.send(8'h81, 1'b1, 1'b0);
      uref_peer_inst.brk();
      uref_peer_inst.send(8'hA5, 1'b1, 1'b1);
      rdc(uref_pkg::OFS_FLAG, 16'h0080);
      for (int i = 0; i < 4; i++) begin
         rdc(uref_pkg::OFS_DATA, dr_exp[i]);
         rdc(uref_pkg::OFS_RSR, {12'h000, st_exp[i]});
      end
      rdc(uref_pkg::OFS_FLAG, 16'h0090);
      wr(uref_pkg::OFS_RSR, 16'hFFFF);
      rdc(uref_pkg::OFS_RSR, 16'h0000);
      // Stick parity with even select expects a zero parity bit; the peer sends a one.
      wr(uref_pkg::OFS_CR, 16'h0300);
      wr(uref_pkg::OFS_LCR, 16'h00F6);
      wr(uref_pkg::OFS_CR, 16'h0301);
      uref_peer_inst.send(8'h01, 1'b1, 1'b1);
      rdc(uref_pkg::OFS_DATA, 16'h0201);
      rdc(uref_pkg::OFS_RSR, 16'h0002);
      // Modem inputs change on a clock edge like every other input.
      @(posedge clk_sys);
      {uref_peer_inst.ring_in_n, uref_peer_inst.carrier_in_n} <= 2'b00;
      {uref_peer_inst.set_ready_in_n, uref_peer_inst.clear_send_in_n} <= 2'b00;
      repeat (4) @(posedge clk_sys);
      rdc(uref_pkg::OFS_FLAG, 16'h0197);
      rdc(12'h100, 16'h0000);
      final_report();
   end
endmodule // uref_core_bench
`default_nettype wire
